// file: hdl/rspm_pkg.sv
// Package for the reset source priority manager
package rspm_pkg;

  // ****************************************************************
  // Reset states, one-hot
  // ****************************************************************
  typedef enum logic [5:0] {
    RSPM_IDLE     = 6'h01,
    RSPM_GENERAL  = 6'h02,
    RSPM_BACKUP   = 6'h04,
    RSPM_WATCHDOG = 6'h08,
    RSPM_SOFTWARE = 6'h10,
    RSPM_USER     = 6'h20
  } rspm_state_t;

  // Reset cause codes reported on the cause output
  localparam logic [2:0] CAUSE_GENERAL = 3'h0;
  localparam logic [2:0] CAUSE_BACKUP = 3'h1;
  localparam logic [2:0] CAUSE_WATCHDOG = 3'h2;
  localparam logic [2:0] CAUSE_SOFTWARE = 3'h3;
  localparam logic [2:0] CAUSE_USER = 3'h4;

  // Reset pulse length in cycles
  localparam int PULSE_CYCLES = 8;
  localparam logic [2:0] CAUSE_RESET = 3'h0;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic general;
    logic backup;
    logic watchdog;
    logic software;
    logic user;
  } rspm_req_t;

  typedef struct packed {
    logic app_proc_rst_n;
    logic met_proc_rst_n;
    logic wdt_rst_n;
  } rspm_rst_t;

endpackage : rspm_pkg

// file: hdl/rspm_edge.sv
// Rising edge detector for one request line
`timescale 1ns/1ps
`default_nettype none
module rspm_edge (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic level_i,
  output logic rise_o
);

  typedef struct packed {
    logic prev;
  } rspm_edge_st_t;

  rspm_edge_st_t st;
  rspm_edge_st_t next_st;

  always_comb begin
    next_st = st;
    next_st.prev = level_i;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rise_o = level_i & ~st.prev;

endmodule : rspm_edge
`default_nettype wire

// file: hdl/rspm_top.sv
// Reset source priority manager top
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Priority order general, backup, watchdog, software, user; highest wins.
// - In user reset, watchdog events are not taken.
// - In user reset, software reset requests are ignored.
// - In software reset, watchdog event moves to watchdog reset.
// - In software reset, external reset pin is ignored.
// - In watchdog reset, software reset requests are ignored.
// - In watchdog reset, user reset is never entered.
// - One manager drives resets of both application and metrology subsystems.
module rspm_top #(
  parameter int PULSE_LEN = rspm_pkg::PULSE_CYCLES
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic general_req_i,
  input wire logic backup_req_i,
  input wire logic watchdog_evt_i,
  input wire logic software_req_i,
  input wire logic external_reset_pin_n_i,
  output var rspm_pkg::rspm_rst_t rst_o,
  output logic [2:0] cause_o,
  output logic busy_o
);

  // ****************************************************************
  // Reset release synchroniser
  // ****************************************************************
  logic [1:0] rsync;
  logic rst_n;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rsync <= 2'h0;
    end else begin
      rsync <= {rsync[0], 1'h1};
    end
  end

  assign rst_n = rsync[1];

  // ****************************************************************
  // Request edges
  // ****************************************************************
  rspm_pkg::rspm_req_t lvl;
  rspm_pkg::rspm_req_t rise;

  assign lvl = '{
    general: general_req_i,
    backup: backup_req_i,
    watchdog: watchdog_evt_i,
    software: software_req_i,
    user: ~external_reset_pin_n_i
  };

  for (genvar g = 0; g < $bits(rspm_pkg::rspm_req_t); g++) begin : g_edge
    rspm_edge u_edge (
      .clk_i(mclk_i),
      .rst_n_i(rst_n),
      .level_i(lvl[g]),
      .rise_o(rise[g])
    );
  end

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    rspm_pkg::rspm_state_t state;
    logic [7:0] count;
    logic [2:0] cause;
    logic proc_rst_n;
    logic wdt_rst_n;
    logic armed;
  } rspm_st_t;

  rspm_st_t st;
  rspm_st_t next_st;
  logic enter;
  rspm_pkg::rspm_state_t target;
  logic [2:0] target_cause;

  always_comb begin
    next_st = st;
    enter = 1'b0;
    target = st.state;
    target_cause = st.cause;
    next_st.armed = 1'b1;
    // Highest accepted source wins; a level held across release is no edge
    if (!st.armed) begin
      enter = 1'b0;
    end else if (rise.general) begin
      enter = 1'b1;
      target = rspm_pkg::RSPM_GENERAL;
      target_cause = rspm_pkg::CAUSE_GENERAL;
    end else if (rise.backup && st.state != rspm_pkg::RSPM_GENERAL) begin
      enter = 1'b1;
      target = rspm_pkg::RSPM_BACKUP;
      target_cause = rspm_pkg::CAUSE_BACKUP;
    end else begin
      case (st.state)
        rspm_pkg::RSPM_IDLE: begin
          if (rise.watchdog) begin
            enter = 1'b1;
            target = rspm_pkg::RSPM_WATCHDOG;
            target_cause = rspm_pkg::CAUSE_WATCHDOG;
          end else if (rise.software) begin
            enter = 1'b1;
            target = rspm_pkg::RSPM_SOFTWARE;
            target_cause = rspm_pkg::CAUSE_SOFTWARE;
          end else if (rise.user) begin
            enter = 1'b1;
            target = rspm_pkg::RSPM_USER;
            target_cause = rspm_pkg::CAUSE_USER;
          end
        end
        rspm_pkg::RSPM_SOFTWARE: begin
          // Pin edges not looked at here
          if (rise.watchdog) begin
            enter = 1'b1;
            target = rspm_pkg::RSPM_WATCHDOG;
            target_cause = rspm_pkg::CAUSE_WATCHDOG;
          end
        end
        // Watchdog and software requests dropped in user reset
        rspm_pkg::RSPM_USER: begin
          enter = 1'b0;
        end
        // Software and pin dropped in watchdog reset
        rspm_pkg::RSPM_WATCHDOG: begin
          enter = 1'b0;
        end
        // Lower sources dropped, not queued
        rspm_pkg::RSPM_GENERAL: begin
          enter = 1'b0;
        end
        rspm_pkg::RSPM_BACKUP: begin
          enter = 1'b0;
        end
        default: begin
          enter = 1'b0;
        end
      endcase
    end

    if (enter) begin
      next_st.state = target;
      next_st.cause = target_cause;
      next_st.count = 8'(PULSE_LEN - 1);
    end else if (st.state != rspm_pkg::RSPM_IDLE) begin
      if (st.count != 8'h00) begin
        next_st.count = st.count - 8'h01;
      end else if (st.state == rspm_pkg::RSPM_USER && !external_reset_pin_n_i) begin
        next_st.count = 8'h00;
      end else begin
        next_st.state = rspm_pkg::RSPM_IDLE;
      end
    end

    next_st.proc_rst_n = (next_st.state == rspm_pkg::RSPM_IDLE);
    next_st.wdt_rst_n = (next_st.state == rspm_pkg::RSPM_IDLE) ||
                        (next_st.state == rspm_pkg::RSPM_SOFTWARE);
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      st.state <= rspm_pkg::RSPM_IDLE;
      st.count <= 8'h00;
      st.cause <= rspm_pkg::CAUSE_RESET;
      st.proc_rst_n <= 1'b0;
      st.wdt_rst_n <= 1'b0;
      st.armed <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // Outputs, both subsystems share one manager
  // ****************************************************************
  assign rst_o = '{
    app_proc_rst_n: st.proc_rst_n,
    met_proc_rst_n: st.proc_rst_n,
    wdt_rst_n: st.wdt_rst_n
  };
  assign cause_o = st.cause;
  assign busy_o = (st.state != rspm_pkg::RSPM_IDLE);

endmodule : rspm_top
`default_nettype wire

// file: tb/rspm_props.sv
// Checker for the reset source priority manager
`timescale 1ns/1ps
`default_nettype none
module rspm_props (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic general_req_i,
  input wire logic backup_req_i,
  input wire logic watchdog_evt_i,
  input wire logic software_req_i,
  input wire logic external_reset_pin_n_i,
  input wire rspm_pkg::rspm_rst_t rst_o,
  input wire logic [2:0] cause_o,
  input wire logic busy_o
);
  logic [2:0] live;

  // Design takes requests from the fourth edge after release
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      live <= 3'h0;
    end else if (live != 3'h4) begin
      live <= live + 3'h1;
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i || live != 3'h4);
  sw_take_a: assert property ($rose(software_req_i) && !busy_o && !$rose(general_req_i)
    && !$rose(backup_req_i) && !$rose(watchdog_evt_i)
    |=> busy_o && cause_o == rspm_pkg::CAUSE_SOFTWARE && !rst_o.app_proc_rst_n
    && rst_o.wdt_rst_n) else $error("software reset not taken");
  subsys_pair_a: assert property (rst_o.app_proc_rst_n == rst_o.met_proc_rst_n
    && rst_o.app_proc_rst_n == !busy_o) else $error("subsystem resets differ");
  gen_preempt_a: assert property ($rose(general_req_i)
    |=> busy_o && cause_o == rspm_pkg::CAUSE_GENERAL && !rst_o.wdt_rst_n)
    else $error("general reset not taken");
  bak_preempt_a: assert property ($rose(backup_req_i) && !general_req_i
    && cause_o != rspm_pkg::CAUSE_GENERAL
    |=> busy_o && cause_o == rspm_pkg::CAUSE_BACKUP) else $error("backup reset not taken");
  user_no_wdt_a: assert property (busy_o && cause_o == rspm_pkg::CAUSE_USER
    && $rose(watchdog_evt_i) && !$rose(general_req_i) && !$rose(backup_req_i)
    |=> cause_o == rspm_pkg::CAUSE_USER) else $error("watchdog taken in user reset");
  user_no_sw_a: assert property (busy_o && cause_o == rspm_pkg::CAUSE_USER
    && $rose(software_req_i) && !$rose(general_req_i) && !$rose(backup_req_i)
    |=> cause_o == rspm_pkg::CAUSE_USER) else $error("software taken in user reset");
  sw_to_wdt_a: assert property (busy_o && cause_o == rspm_pkg::CAUSE_SOFTWARE
    && $rose(watchdog_evt_i) && !$rose(general_req_i) && !$rose(backup_req_i)
    |=> busy_o && cause_o == rspm_pkg::CAUSE_WATCHDOG)
    else $error("watchdog lost in software reset");
  sw_pin_a: assert property (busy_o && cause_o == rspm_pkg::CAUSE_SOFTWARE
    && $fell(external_reset_pin_n_i) && !$rose(watchdog_evt_i)
    && !$rose(general_req_i) && !$rose(backup_req_i)
    |=> cause_o == rspm_pkg::CAUSE_SOFTWARE) else $error("pin taken in software reset");
  wdt_hold_a: assert property (busy_o && cause_o == rspm_pkg::CAUSE_WATCHDOG
    && ($rose(software_req_i) || $fell(external_reset_pin_n_i))
    && !$rose(general_req_i) && !$rose(backup_req_i)
    |=> cause_o == rspm_pkg::CAUSE_WATCHDOG) else $error("watchdog reset left");
  c_sw: cover property (busy_o && cause_o == rspm_pkg::CAUSE_SOFTWARE);
  c_user: cover property (busy_o && cause_o == rspm_pkg::CAUSE_USER);
  c_bak: cover property (busy_o && cause_o == rspm_pkg::CAUSE_BACKUP);
endmodule : rspm_props
bind rspm_top rspm_props u_rspm_props (
  .mclk_i(mclk_i),
  .rst_n_i(rst_n_i),
  .general_req_i(general_req_i),
  .backup_req_i(backup_req_i),
  .watchdog_evt_i(watchdog_evt_i),
  .software_req_i(software_req_i),
  .external_reset_pin_n_i(external_reset_pin_n_i),
  .rst_o(rst_o),
  .cause_o(cause_o),
  .busy_o(busy_o)
);
`default_nettype wire

// file: tb/rspm_top_test.sv
// Testbench for the reset source priority manager
`timescale 1ns/1ps
`default_nettype none
module rspm_top_test;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [3:0] req = 4'h0;
  logic pin_n = 1'b1;
  rspm_pkg::rspm_rst_t rst;
  logic [2:0] cause;
  logic busy;
  int n_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  rspm_top #(.PULSE_LEN(4)) u_rspm_top (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .general_req_i(req[3]), .backup_req_i(req[2]), .watchdog_evt_i(req[1]),
    .software_req_i(req[0]), .external_reset_pin_n_i(pin_n), .rst_o(rst),
    .cause_o(cause), .busy_o(busy));
  always #50 mclk_i = ~mclk_i;
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      conclude();
    end
  end
  task conclude;
    if (n_errors == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : conclude
  task step(input int n);
    repeat (n) @(negedge mclk_i);
  endtask : step
  task hit(input int k);
    req[k] = 1'b1;
    step(1);
    req[k] = 1'b0;
  endtask : hit
  task chk(input string what, input logic [2:0] exp, input logic [2:0] got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task st(input logic [2:0] c, input logic b, input logic p, input logic w);
    chk("cause", c, cause);
    chk("busy", {2'h0, b}, {2'h0, busy});
    chk("app", {2'h0, p}, {2'h0, rst.app_proc_rst_n});
    chk("met", {2'h0, p}, {2'h0, rst.met_proc_rst_n});
    chk("wdt", {2'h0, w}, {2'h0, rst.wdt_rst_n});
  endtask : st
  task t_sw;
    hit(0);
    st(3'h3, 1'b1, 1'b0, 1'b1);
    step(3);
    st(3'h3, 1'b1, 1'b0, 1'b1);
    step(1);
    st(3'h3, 1'b0, 1'b1, 1'b1);
  endtask : t_sw
  task t_sw_pin;
    hit(0);
    pin_n = 1'b0;
    step(1);
    st(3'h3, 1'b1, 1'b0, 1'b1);
    hit(1);
    st(3'h2, 1'b1, 1'b0, 1'b0);
    pin_n = 1'b1;
    step(6);
    st(3'h2, 1'b0, 1'b1, 1'b1);
  endtask : t_sw_pin
  task t_user;
    pin_n = 1'b0;
    step(1);
    st(3'h4, 1'b1, 1'b0, 1'b0);
    hit(1);
    hit(0);
    step(6);
    st(3'h4, 1'b1, 1'b0, 1'b0);
    pin_n = 1'b1;
    step(6);
    st(3'h4, 1'b0, 1'b1, 1'b1);
  endtask : t_user
  task t_wdt;
    hit(1);
    hit(0);
    pin_n = 1'b0;
    step(1);
    st(3'h2, 1'b1, 1'b0, 1'b0);
    step(4);
    st(3'h2, 1'b0, 1'b1, 1'b1);
    pin_n = 1'b1;
    step(2);
  endtask : t_wdt
  task t_pre;
    hit(0);
    hit(3);
    hit(2);
    st(3'h0, 1'b1, 1'b0, 1'b0);
    step(6);
    hit(0);
    hit(2);
    st(3'h1, 1'b1, 1'b0, 1'b0);
    step(6);
    st(3'h1, 1'b0, 1'b1, 1'b1);
  endtask : t_pre
  task t_rst;
    hit(0);
    rst_n_i = 1'b0;
    step(1);
    st(3'h0, 1'b0, 1'b0, 1'b0);
    req[0] = 1'b1;
    step(2);
    rst_n_i = 1'b1;
    step(5);
    st(3'h0, 1'b0, 1'b1, 1'b1);
    req[0] = 1'b0;
    step(1);
    hit(0);
    st(3'h3, 1'b1, 1'b0, 1'b1);
    step(4);
    st(3'h3, 1'b0, 1'b1, 1'b1);
  endtask : t_rst
  initial begin
    step(20);
    rst_n_i = 1'b1;
    step(5);
    st(3'h0, 1'b0, 1'b1, 1'b1);
    t_sw();
    t_sw_pin();
    t_user();
    t_wdt();
    t_pre();
    t_rst();
    conclude();
  end
endmodule : rspm_top_test
`default_nettype wire
